/* shared/rpc_pkg.sv */
// rf power mode control package: register indices, field positions, resets
// assumes a 32-bit classic wishbone bus with one aligned word per register
package rpc_pkg;

    // ************************************************************
    // register map (index; byte address is four times the index)
    // ************************************************************
    localparam int RPC_IDX_W = 10;
    localparam logic [9:0] RPC_IDX_CTRL = 10'h0C8;
    localparam logic [9:0] RPC_IDX_STAT = 10'h0C9;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int RPC_BIT_DIR = 7;
    localparam int RPC_BIT_FSET = 6;
    localparam int RPC_BIT_RX_SLEEP = 5;
    localparam int RPC_BIT_TX_SLEEP = 4;
    localparam int RPC_BIT_FS_SLEEP = 3;
    localparam int RPC_BIT_XC_SLEEP = 2;
    localparam int RPC_BIT_BIAS_SLEEP = 1;
    localparam logic [7:0] RPC_CTRL_RST = 8'h38;
    localparam logic [7:0] RPC_CTRL_WMASK = 8'hFE;

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int RPC_ST_RX_READY = 0;
    localparam int RPC_ST_TX_READY = 1;
    localparam int RPC_ST_ALL_SLEEP = 2;
    localparam logic [7:0] RPC_STAT_RST = 8'h00;

endpackage : rpc_pkg

/* src/rpc_wb_slave.sv */
// classic wishbone slave front end: decode, write strobe, ack, read data
// assumes a master that holds its request until it samples ack high
`timescale 1ns/1ns
module rpc_wb_slave #(
    parameter int ADR_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] ctrl_rd_i,
    input wire logic [7:0] stat_rd_i,
    output logic wr_ctrl_o,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rpc_slv_t;

    rpc_slv_t s_q;
    rpc_slv_t s_d;
    logic req;

    function automatic logic hit(input logic [ADR_W-1:0] adr,
                                 input logic [9:0] idx);
        hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
    endfunction : hit

    // ************************************************************
    // decode
    // ************************************************************
    // ack drops the cycle after it rose, so one request gives one ack
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    // write lands on the same edge that raises ack
    assign wr_ctrl_o = req & wb_we_i & wb_sel_i[0]
                       & hit(wb_adr_i, rpc_pkg::RPC_IDX_CTRL);

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (req && !wb_we_i) begin
            if (hit(wb_adr_i, rpc_pkg::RPC_IDX_CTRL)) begin
                s_d.dat = {24'h000000, ctrl_rd_i};
            end else if (hit(wb_adr_i, rpc_pkg::RPC_IDX_STAT)) begin
                s_d.dat = {24'h000000, stat_rd_i};
            end else begin
                // unmapped: acked, reads zero
                s_d.dat = 32'h00000000;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;

endmodule : rpc_wb_slave

/* src/rpc_power_mode_ctrl.sv */
// rf power mode control register with wishbone access
// assumes software picks the modem data format before waking sections
`timescale 1ns/1ns
module rpc_power_mode_ctrl #(
    parameter int ADR_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic direction_select_o,
    output logic freq_set_b_o,
    output logic receiver_sleep_o,
    output logic transmitter_sleep_o,
    output logic synthesizer_sleep_o,
    output logic crystal_core_sleep_o,
    output logic bias_sleep_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
    } rpc_state_t;

    rpc_state_t s_q;
    rpc_state_t s_d;
    logic wr_ctrl;
    logic rx_path_up;
    logic tx_path_up;
    logic clocks_up;

    // ************************************************************
    // bus front end
    // ************************************************************
    rpc_wb_slave #(
        .ADR_W(ADR_W)
    ) u_slave (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .ctrl_rd_i(s_q.ctrl),
        .stat_rd_i(s_q.stat),
        .wr_ctrl_o(wr_ctrl),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o)
    );

    // ************************************************************
    // readiness of the active direction
    // ************************************************************
    // clocks need core, bias/buffer and synthesizer all awake
    assign clocks_up = ~s_q.ctrl[rpc_pkg::RPC_BIT_XC_SLEEP]
                       & ~s_q.ctrl[rpc_pkg::RPC_BIT_BIAS_SLEEP]
                       & ~s_q.ctrl[rpc_pkg::RPC_BIT_FS_SLEEP];
    assign rx_path_up = clocks_up & ~s_q.ctrl[rpc_pkg::RPC_BIT_DIR]
                        & ~s_q.ctrl[rpc_pkg::RPC_BIT_RX_SLEEP];
    assign tx_path_up = clocks_up & s_q.ctrl[rpc_pkg::RPC_BIT_DIR]
                        & ~s_q.ctrl[rpc_pkg::RPC_BIT_TX_SLEEP];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        if (wr_ctrl) begin
            // all seven bits written as one byte, no coupling
            // bit 0 masked off so it always reads zero
            s_d.ctrl = wb_dat_i[7:0] & rpc_pkg::RPC_CTRL_WMASK;
        end
        // status lags the control byte by one cycle; read-only
        s_d.stat = 8'h00;
        s_d.stat[rpc_pkg::RPC_ST_RX_READY] = rx_path_up;
        s_d.stat[rpc_pkg::RPC_ST_TX_READY] = tx_path_up;
        s_d.stat[rpc_pkg::RPC_ST_ALL_SLEEP] =
            s_q.ctrl[rpc_pkg::RPC_BIT_RX_SLEEP]
            & s_q.ctrl[rpc_pkg::RPC_BIT_TX_SLEEP]
            & s_q.ctrl[rpc_pkg::RPC_BIT_FS_SLEEP];
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q.ctrl <= rpc_pkg::RPC_CTRL_RST;
            s_q.stat <= rpc_pkg::RPC_STAT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // section controls, straight from the control byte
    // ************************************************************
    assign direction_select_o = s_q.ctrl[rpc_pkg::RPC_BIT_DIR];
    // set choice left to software, no auto swap on direction
    assign freq_set_b_o = s_q.ctrl[rpc_pkg::RPC_BIT_FSET];
    assign receiver_sleep_o =
        s_q.ctrl[rpc_pkg::RPC_BIT_RX_SLEEP];
    assign transmitter_sleep_o =
        s_q.ctrl[rpc_pkg::RPC_BIT_TX_SLEEP];
    assign synthesizer_sleep_o =
        s_q.ctrl[rpc_pkg::RPC_BIT_FS_SLEEP];
    assign crystal_core_sleep_o =
        s_q.ctrl[rpc_pkg::RPC_BIT_XC_SLEEP];
    assign bias_sleep_o =
        s_q.ctrl[rpc_pkg::RPC_BIT_BIAS_SLEEP];

endmodule : rpc_power_mode_ctrl

/* verification/rpc_power_mode_ctrl_checker.sv */
// checker for the rf power mode control register
// assumes a wishbone master that holds each request until ack
`timescale 1ns/1ns
module rpc_power_mode_ctrl_checker #(
    parameter int ADR_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic direction_select_o,
    input wire logic freq_set_b_o,
    input wire logic receiver_sleep_o,
    input wire logic transmitter_sleep_o,
    input wire logic synthesizer_sleep_o,
    input wire logic crystal_core_sleep_o,
    input wire logic bias_sleep_o
);
    // ************************************************************
    // properties
    // ************************************************************
    wire logic [6:0] pins = {direction_select_o, freq_set_b_o,
        receiver_sleep_o, transmitter_sleep_o, synthesizer_sleep_o,
        crystal_core_sleep_o, bias_sleep_o};
    wire logic hit = wb_adr_i[ADR_W-1:2] == rpc_pkg::RPC_IDX_CTRL;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ctrl_wr;
        s_take ##0 (wb_we_i && wb_sel_i[0] && hit);
    endsequence
    property p_bit(logic o, int b);
        s_ctrl_wr |=> o == $past(wb_dat_i[b]);
    endproperty
    a_dir_write: assert property (p_bit(direction_select_o, 7))
        else $error("direction mismatch");
    a_fset_write: assert property (p_bit(freq_set_b_o, 6))
        else $error("frequency set mismatch");
    a_rx_sleep: assert property (p_bit(receiver_sleep_o, 5))
        else $error("receiver sleep mismatch");
    a_tx_sleep: assert property (p_bit(transmitter_sleep_o, 4))
        else $error("transmitter sleep mismatch");
    a_fs_sleep: assert property (p_bit(synthesizer_sleep_o, 3))
        else $error("synthesizer sleep mismatch");
    a_core_sleep: assert property (p_bit(crystal_core_sleep_o, 2))
        else $error("crystal core sleep mismatch");
    a_bias_sleep: assert property (p_bit(bias_sleep_o, 1))
        else $error("bias sleep mismatch");
    a_ack_pulse: assert property
        (s_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");
    a_sleep_hold: assert property
        (!(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(pins))
        else $error("outputs moved without a write");
    a_read_back: assert property
        (s_take ##0 (!wb_we_i && hit) |=> wb_dat_o == {24'h0, pins, 1'b0})
        else $error("read data mismatch");
endmodule : rpc_power_mode_ctrl_checker

bind rpc_power_mode_ctrl rpc_power_mode_ctrl_checker #(.ADR_W(ADR_W))
    rpc_power_mode_ctrl_checker_inst (.core_clk_i, .rstn_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
    .wb_dat_o, .direction_select_o, .freq_set_b_o, .receiver_sleep_o,
    .transmitter_sleep_o, .synthesizer_sleep_o, .crystal_core_sleep_o,
    .bias_sleep_o);

/* verification/rpc_power_mode_ctrl_test.sv */
// self-checking bench for the rf power mode control register
// assumes the package and the design are compiled first
`timescale 1ns/1ns
module rpc_power_mode_ctrl_test;
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    wire logic [6:0] pins;
    logic [15:0] tbl [3] = '{16'h0001, 16'h8002, 16'h3804};
    int fails = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    rpc_power_mode_ctrl rpc_power_mode_ctrl_inst (.core_clk_i, .rstn_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_ack_o, .wb_dat_o, .direction_select_o(pins[6]),
        .freq_set_b_o(pins[5]), .receiver_sleep_o(pins[4]),
        .transmitter_sleep_o(pins[3]), .synthesizer_sleep_o(pins[2]),
        .crystal_core_sleep_o(pins[1]), .bias_sleep_o(pins[0]));
    initial forever #2 core_clk_i = ~core_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // pin levels, bit 6 direction down to bit 0 bias sleep
    task automatic chk_pins(input logic [6:0] exp);
        chk({25'h0, pins}, {25'h0, exp});
    endtask : chk_pins
    // master waits for ack with no cycle count; the timeout cuts hangs
    task automatic wb(input logic we, input logic [11:0] a,
            input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF);
        chk(q, e);
    endtask : rd
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    always @(posedge core_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd(12'h320, 32'h38);
        chk_pins(7'h1C);
        // modem format taken as chosen before any wake-up
        for (int i = 1; i < 8; i++) begin
            wb(1'b1, 12'h320, 32'h1 | (32'h1 << i), 4'h1);
            chk_pins(7'h01 << (i - 1));
            rd(12'h320, 32'h1 << i);
        end
        // receive on set B, transmit on set A: software flips the bit
        wb(1'b1, 12'h320, 32'h40, 4'h1);
        chk_pins(7'h20);
        wb(1'b1, 12'h320, 32'h80, 4'h1);
        chk_pins(7'h40);
        wb(1'b1, 12'h320, 32'hFF, 4'hF);
        wb(1'b1, 12'h320, 32'h00, 4'hE);
        rd(12'h320, 32'hFE);
        wb(1'b1, 12'h100, 32'h00, 4'hF);
        rd(12'h100, 32'h0);
        rd(12'h320, 32'hFE);
        foreach (tbl[k]) begin
            wb(1'b1, 12'h320, {24'h0, tbl[k][15:8]}, 4'hF);
            rd(12'h324, {24'h0, tbl[k][7:0]});
        end
        // reset in mid-run must restore the power-on byte
        wb(1'b1, 12'h320, 32'hC6, 4'h1);
        rd(12'h320, 32'hC6);
        rstn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd(12'h320, 32'h38);
        final_report();
    end
endmodule : rpc_power_mode_ctrl_test
